// ---- hdl/rppi_port.v ----
// Radio parallel port top: 16 open-collector data lines, strobe, two
// interrupt inputs, APB register slave. Assumes external pull-ups on the
// data lines and interrupt pins; all pins are asynchronous to clk_sys.
`timescale 1ns/100ps
`include "rppi_regs.vh"
module rppi_port #(
  parameter WIDTH = 16,
  parameter STROBE_CYC = `RPPI_STROBE_CYC
) (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [WIDTH-1:0] dataIn,
  output wire [WIDTH-1:0] dataOut,
  output wire [WIDTH-1:0] dataOe,
  output wire strobeOut,
  input wire irq1In,
  input wire irq2In,
  output wire irqOut
);
  localparam [15:0] STROBE_LEN = STROBE_CYC;

  reg [WIDTH-1:0] dirMask_ff;
  reg [WIDTH-1:0] outStage_ff;
  reg [WIDTH-1:0] outLatch_ff;
  reg [WIDTH-1:0] sample_ff;
  reg [2:0] ctrl_ff;
  reg [15:0] stat_ff;
  reg [15:0] ien_ff;
  reg tripped1_ff;
  reg tripped2_ff;
  reg disarmed1_ff;
  reg disarmed2_ff;
  reg strobeAct_ff;
  reg [15:0] strobeCnt_ff;
  reg [15:0] nxt_stat;
  wire [WIDTH-1:0] pinSync;
  wire [1:0] irqSync;
  wire wrEn;
  wire rdEn;
  wire addrOk;
  wire sendCmd;
  wire readCmd;
  wire arm1;
  wire arm2;
  wire pol;
  wire trip1Set;
  wire trip2Set;
  wire [WIDTH-1:0] pinLevel;

  // Single-cycle APB answer; an unmapped address gets pslverr
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign addrOk = (paddr == `RPPI_OFS_DIR) || (paddr == `RPPI_OFS_OUT) ||
    (paddr == `RPPI_OFS_CMD) || (paddr == `RPPI_OFS_SAMPLE) ||
    (paddr == `RPPI_OFS_CTRL) || (paddr == `RPPI_OFS_STAT) ||
    (paddr == `RPPI_OFS_CLR) || (paddr == `RPPI_OFS_IEN) ||
    (paddr == `RPPI_OFS_PINS);
  assign pslverr = psel & penable & ~addrOk;

  assign sendCmd = wrEn && (paddr == `RPPI_OFS_CMD) && pwdata[`RPPI_CMD_SEND];
  assign readCmd = wrEn && (paddr == `RPPI_OFS_CMD) && pwdata[`RPPI_CMD_READ];
  assign pol = ctrl_ff[`RPPI_CTRL_POL];
  assign arm1 = ctrl_ff[`RPPI_CTRL_ARM1];
  assign arm2 = ctrl_ff[`RPPI_CTRL_ARM2];

  // Pins pass four flops; resets high to match the idle pulled-up lines
  rppi_sync #(
    .WIDTH(WIDTH),
    .INIT({WIDTH{1'b1}})
  ) u_pinSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(dataIn),
    .dout(pinSync)
  );

  rppi_sync #(
    .WIDTH(2),
    .INIT(2'b11)
  ) u_irqSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({irq2In, irq1In}),
    .dout(irqSync)
  );

  // Open collector: only ever drive low, never high
  assign pinLevel = dirMask_ff | outLatch_ff;
  assign dataOut = {WIDTH{1'b0}};
  assign dataOe = ~pinLevel;

  // Lines we pull low read low even if the far side fights the pull
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sample_ff <= {WIDTH{1'b0}};
    end else if (readCmd) begin
      sample_ff <= pinSync & pinLevel;
    end
  end

  // Direction, staging and control registers
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dirMask_ff <= `RPPI_RST_DIR;
      outStage_ff <= `RPPI_RST_OUT;
      outLatch_ff <= `RPPI_RST_OUT;
      ctrl_ff <= `RPPI_RST_CTRL;
      ien_ff <= 16'h0000;
    end else begin
      if (wrEn && paddr == `RPPI_OFS_DIR) begin
        dirMask_ff <= pwdata[WIDTH-1:0];
      end
      if (wrEn && paddr == `RPPI_OFS_OUT) begin
        outStage_ff <= pwdata[WIDTH-1:0];
      end
      if (sendCmd) begin
        outLatch_ff <= outStage_ff;
      end
      if (wrEn && paddr == `RPPI_OFS_CTRL) begin
        ctrl_ff <= pwdata[2:0];
      end
      if (wrEn && paddr == `RPPI_OFS_IEN) begin
        ien_ff <= pwdata[15:0];
      end
    end
  end

  // Strobe pulse starts with the data edge; a new send restarts it
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strobeAct_ff <= 1'b0;
      strobeCnt_ff <= 16'h0000;
    end else if (sendCmd) begin
      strobeAct_ff <= 1'b1;
      strobeCnt_ff <= STROBE_LEN;
    end else if (strobeAct_ff) begin
      if (strobeCnt_ff <= 16'h0001) begin
        strobeAct_ff <= 1'b0;
        strobeCnt_ff <= 16'h0000;
      end else begin
        strobeCnt_ff <= strobeCnt_ff - 16'h0001;
      end
    end
  end
  // Polarity bit high means active-high pulse; idle is the opposite level
  assign strobeOut = pol ? strobeAct_ff : ~strobeAct_ff;

  // Disabling clears the trip; arming alone never does
  assign trip1Set = arm1 & ~disarmed1_ff & ~irqSync[0];
  assign trip2Set = arm2 & ~disarmed2_ff & ~irqSync[1];
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tripped1_ff <= 1'b0;
      tripped2_ff <= 1'b0;
      disarmed1_ff <= 1'b1;
      disarmed2_ff <= 1'b1;
    end else begin
      if (!arm1) begin
        tripped1_ff <= 1'b0;
        disarmed1_ff <= 1'b0;
      end else if (trip1Set) begin
        tripped1_ff <= 1'b1;
        disarmed1_ff <= 1'b1; // Latched until the next disable
      end
      if (!arm2) begin
        tripped2_ff <= 1'b0;
        disarmed2_ff <= 1'b0;
      end else if (trip2Set) begin
        tripped2_ff <= 1'b1;
        disarmed2_ff <= 1'b1;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always @* begin
    nxt_stat = stat_ff;
    if (wrEn && paddr == `RPPI_OFS_CLR) begin
      nxt_stat = stat_ff & ~pwdata[15:0];
    end
    if (trip1Set) begin
      nxt_stat[`RPPI_ST_TRIP1] = 1'b1;
    end
    if (trip2Set) begin
      nxt_stat[`RPPI_ST_TRIP2] = 1'b1;
    end
    if (sendCmd) begin
      nxt_stat[`RPPI_ST_SENT] = 1'b1;
    end
    if (readCmd) begin
      nxt_stat[`RPPI_ST_READ] = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_ff <= 16'h0000;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign irqOut = |(stat_ff & ien_ff);

  // Read mux; zero for write-only and unmapped words
  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `RPPI_OFS_DIR: prdata[WIDTH-1:0] = dirMask_ff;
      `RPPI_OFS_OUT: prdata[WIDTH-1:0] = outStage_ff;
      `RPPI_OFS_SAMPLE: prdata[WIDTH-1:0] = sample_ff;
      `RPPI_OFS_CTRL: prdata[4:0] = {tripped2_ff, tripped1_ff, ctrl_ff};
      `RPPI_OFS_STAT: prdata[15:0] = stat_ff;
      `RPPI_OFS_IEN: prdata[15:0] = ien_ff;
      `RPPI_OFS_PINS: prdata[WIDTH-1:0] = pinLevel;
      default: prdata = 32'h00000000;
    endcase
  end
endmodule

// ---- hdl/rppi_regs.vh ----
// Register map, field positions, reset values and timing counts of the
// radio parallel port. Assumes a 250 MHz system clock and an APB slave.
//
// Summary of operation
// - Each set direction bit makes its line an input by releasing the driver.
// - Sample command captures all sixteen lines, outputs included.
// - A line held low by our driver always samples low.
// - Writing direction drives it too; pin level is direction OR output value.
// - Output value is staged; it reaches the pins only on the drive command.
// - Output bit 0 pulls the line low, bit 1 releases it high.
// - Each drive command emits a strobe pulse of selectable polarity.
// - Outputs can be updated at about 200 kb/s below 158 pF load.
// - An armed interrupt input trips when its pin is seen low.
// - A trip holds until disabled, which clears it; arming alone keeps it.
// - A trip sets a pollable status bit that can raise a service request.
// - Direction 0x00ff, output zero, no input low: sample reads 255.
// - Output 0xff00 then drive: upper eight lines high, rest low.
// - Interrupt one trip is status bit 13, interrupt two bit 14.
// - A disabled interrupt input ignores its pin entirely.
// - Bit 0 of direction, output and sample maps to line zero.
`ifndef RPPI_REGS_VH
`define RPPI_REGS_VH

`define RPPI_OFS_DIR 12'h000
`define RPPI_OFS_OUT 12'h004
`define RPPI_OFS_CMD 12'h008
`define RPPI_OFS_SAMPLE 12'h00c
`define RPPI_OFS_CTRL 12'h010
`define RPPI_OFS_STAT 12'h014
`define RPPI_OFS_CLR 12'h018
`define RPPI_OFS_IEN 12'h01c
`define RPPI_OFS_PINS 12'h020

`define RPPI_CMD_SEND 0
`define RPPI_CMD_READ 1
`define RPPI_CTRL_POL 0
`define RPPI_CTRL_ARM1 1
`define RPPI_CTRL_ARM2 2
`define RPPI_ST_TRIP1 13
`define RPPI_ST_TRIP2 14
`define RPPI_ST_SENT 0
`define RPPI_ST_READ 1

`define RPPI_RST_DIR 16'h0000
`define RPPI_RST_OUT 16'h0000
`define RPPI_RST_CTRL 3'h0

`define RPPI_CLK_MHZ 250
`define RPPI_STROBE_NS 1000
`define RPPI_STROBE_CYC ((`RPPI_STROBE_NS * `RPPI_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/rppi_sync.v ----
// Three-stage pin synchroniser with agreement check.
// Assumes asynchronous pins and the system clock domain.
`timescale 1ns/100ps
module rppi_sync #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire nrst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  integer i;

  // Output only moves where stages two and three agree, filtering glitches
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      dout <= INIT;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          dout[i] <= stage3_ff[i];
        end
      end
    end
  end
endmodule

// ---- verif/rppi_far_end.sv ----
// Far-end model: pull-ups on the lines, optional low pulls, word latch.
// Assumes the bench tells it the strobe polarity.
`timescale 1ns/100ps
module rppi_far_end (
  input wire clk_sys,
  input wire [15:0] dataOe,
  input wire [15:0] extLow,
  input wire strobeOut,
  input wire strobePol,
  output wire [15:0] dataIn,
  output logic [15:0] latched
);
  // Wired-AND of both drivers over the pull-up
  assign dataIn = ~(dataOe | extLow);
  // Latch at the active level, once data settled
  always @(posedge clk_sys)
    if (strobeOut === strobePol)
      latched <= dataIn;
endmodule

// ---- verif/rppi_port_chk.sv ----
// Checker on rppi_port pins: APB answer, line release, strobe pulse.
// Assumes aligned addresses and a strobe of four cycles.
`timescale 1ns/100ps
module rppi_port_chk #(
  parameter WIDTH = 16,
  parameter STROBE_CYC = 4
) (
  input wire clk_sys, nrst, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire pready, pslverr, strobeOut, irq1In, irq2In, irqOut,
  input wire [WIDTH-1:0] dataIn, dataOut, dataOe
);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire send = wr && paddr == 12'h008 && pwdata[0];
  wire oeWr = send || (wr && paddr == 12'h000);
  reg pol_ff;
  reg [1:0] up_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Polarity shadow; up_ff skips the edges just after reset
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pol_ff <= 1'b0;
      up_ff <= 2'h0;
    end else begin
      if (wr && paddr == 12'h010)
        pol_ff <= pwdata[0];
      if (!up_ff[1])
        up_ff <= up_ff + 2'h1;
    end
  end
  // Pulse length tied to the bench's short strobe
  sequence pulseOn;
    (strobeOut == pol_ff) [*4];
  endsequence
  sequence sendQuiet;
    send ##1 !send [*4];
  endsequence
  pready_a: assert property (pready) else $error("no pready");
  unmapped_a: assert property (acc && paddr > 12'h020 |-> pslverr && prdata == 32'h0)
    else $error("bad address taken");
  mapped_a: assert property (acc && paddr <= 12'h020 |-> !pslverr)
    else $error("good address refused");
  line_low_a: assert property (dataOut == 16'h0) else $error("line driven high");
  dir_release_a: assert property (wr && paddr == 12'h000 |=>
    (dataOe & $past(pwdata[15:0])) == 16'h0) else $error("input line driven");
  oe_cause_a: assert property ($changed(dataOe) && up_ff[1] |-> $past(oeWr))
    else $error("lines moved unasked");
  strobe_on_a: assert property (send |=> pulseOn) else $error("no strobe");
  strobe_end_a: assert property (sendQuiet |=> strobeOut != pol_ff)
    else $error("strobe too long");
endmodule
bind rppi_port rppi_port_chk #(.WIDTH(WIDTH), .STROBE_CYC(STROBE_CYC)) chk (.*);

// ---- verif/test_radio_parallel_port_irq.sv ----
// Bench for rppi_port: APB tasks, far-end model on the lines.
// Assumes zero-wait APB; strobe shortened to four cycles.
`timescale 1ns/100ps
module test_radio_parallel_port_irq;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic irq1In = 1'b1, irq2In = 1'b1, strobePol = 1'b0, rdErr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] extLow = 16'h0;
  wire [15:0] latched, dataIn, dataOut, dataOe;
  wire [31:0] prdata;
  wire pready, pslverr, strobeOut, irqOut;
  int errors = 0, n_compared = 0;
  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  rppi_port #(.STROBE_CYC(4)) uut (.*);
  rppi_far_end far (.*);
  task close_out;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_compared++;
      if (g !== e) begin
        errors++;
        $display("unexpected at %0t: %h not %h", $time, g, e);
      end
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // One APB transfer, then an idle cycle so no signal is set twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
        errors++;
        close_out;
      end
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  // Synchroniser needs a few cycles before a sample is true
  task samp(input logic [31:0] e);
    begin
      cyc(8);
      wr(12'h008, 32'h2);
      rchk(12'h00c, e);
    end
  endtask
  // Reset, then line, strobe and interrupt sequences
  initial begin
    cyc(8);
    nrst <= 1'b1;
    cyc(1);
    chk(strobeOut, 32'h1);
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    rchk(12'h010, 32'h0);
    wr(12'h000, 32'h00ff);
    chk(dataOe, 32'hff00);
    rchk(12'h020, 32'h00ff);
    samp(32'h00ff);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'hff00);
    chk(dataOe, 32'hffff);
    wr(12'h008, 32'h1);
    chk(strobeOut, 32'h0);
    chk(dataOe, 32'h00ff);
    cyc(6);
    chk(strobeOut, 32'h1);
    chk(latched, 32'hff00);
    samp(32'hff00);
    wr(12'h000, 32'h00ff);
    extLow <= 16'h0f0f;
    cyc(5000);
    samp(32'hf0f0);
    strobePol <= 1'b1;
    wr(12'h010, 32'h1);
    wr(12'h008, 32'h1);
    chk(strobeOut, 32'h1);
    cyc(6);
    chk(strobeOut, 32'h0);
    wr(12'h018, 32'hffff);
    wr(12'h01c, 32'h6000);
    wr(12'h010, 32'h3);
    irq2In <= 1'b0;
    irq1In <= 1'b0;
    cyc(10);
    irq1In <= 1'b1;
    cyc(10);
    rchk(12'h014, 32'h2000);
    chk(irqOut, 32'h1);
    wr(12'h010, 32'h3);
    rchk(12'h010, 32'hb);
    wr(12'h018, 32'h2000);
    chk(irqOut, 32'h0);
    wr(12'h010, 32'h1);
    wr(12'h010, 32'h3);
    rchk(12'h010, 32'h3);
    wr(12'h010, 32'h5);
    cyc(10);
    rchk(12'h014, 32'h4000);
    wr(12'h01c, 32'h0);
    chk(irqOut, 32'h0);
    wr(12'h100, 32'hffff);
    rchk(12'h100, 32'h0);
    chk(rdErr, 32'h1);
    rchk(12'h01c, 32'h0);
    chk(rdErr, 32'h0);
    rchk(12'h000, 32'h00ff);
    close_out;
  end
endmodule
